// ---- shared/ast_consts.svh ----
// register map, field positions, reset values and timing counts of the serial transceiver
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define AST_OFS_INTCTL  8'h0b
`define AST_OFS_FLAGS   8'h0c
`define AST_OFS_RXSTAT  8'h18
`define AST_OFS_TXDATA  8'h19
`define AST_OFS_RXDATA  8'h1a
`define AST_OFS_ENABLES 8'h8c
`define AST_OFS_TXSTAT  8'h98
`define AST_OFS_DIVISOR 8'h99

// ****************************************
// field positions
// ****************************************
`define AST_INT_GLOBAL  7
`define AST_INT_PERIPH  6
`define AST_FLG_RXAVAIL 5
`define AST_FLG_TXEMPTY 4
`define AST_RX_PORTEN   7
`define AST_RX_NINE     6
`define AST_RX_CONT     4
`define AST_RX_FRAMING  2
`define AST_RX_OVERRUN  1
`define AST_RX_BIT9     0
`define AST_TX_CLKSRC   7
`define AST_TX_NINE     6
`define AST_TX_ENABLE   5
`define AST_TX_SYNC     4
`define AST_TX_HISPEED  2
`define AST_TX_SHEMPTY  1
`define AST_TX_BIT9     0

// ****************************************
// reset values
// ****************************************
`define AST_RST_BYTE    8'h00
`define AST_RST_TXSTAT  8'h02

// ****************************************
// timing counts
// ****************************************
`define AST_BIT_LAST    4'hf
`define AST_MID_BIT     4'h7
`define AST_PRE_LAST    2'h3
`define AST_LAST8       4'h7
`define AST_LAST9       4'h8

`endif

// ---- shared/ast_pkg.sv ----
// types shared by the serial transceiver modules
package ast_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;
    typedef struct packed {
        logic       framing;
        logic       bit9;
        logic [7:0] data;
    } ast_rx_entry_t;
endpackage

// ---- shared/ast_rx_if.sv ----
// link between the register/fifo logic and the receive shifter
`timescale 1ns/1ps
`default_nettype none
interface ast_rx_if;
    logic       sampleTick;
    logic       rxLevel;
    logic       rxRun;
    logic       nineBit;
    logic       wordDone;
    logic [8:0] wordData;
    logic       stopBit;
    modport ctrl (output sampleTick, output rxLevel, output rxRun, output nineBit,
                  input wordDone, input wordData, input stopBit);
    modport rcv  (input sampleTick, input rxLevel, input rxRun, input nineBit,
                  output wordDone, output wordData, output stopBit);
endinterface
`default_nettype wire

// ---- hdl/ast_rx_shifter.sv ----
// receive data recovery and shift register, oversampled sixteen times per bit
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"
module ast_rx_shifter
    import ast_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    ast_rx_if.rcv     rx
);
    ast_rx_state_t state_reg;
    logic [3:0]    tickCnt_reg;
    logic [3:0]    bitIdx_reg;
    logic [8:0]    shift_reg;
    logic          midBit;
    logic          bitEnd;
    logic [3:0]    lastIdx;

    assign midBit  = rx.sampleTick && tickCnt_reg == `AST_MID_BIT;
    assign bitEnd  = rx.sampleTick && tickCnt_reg == `AST_BIT_LAST;
    assign lastIdx = rx.nineBit ? `AST_LAST9 : `AST_LAST8;

    // ****************************************
    // oversampling state machine
    // ****************************************
    // x16 sampling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= RX_IDLE;
            tickCnt_reg <= 4'h0;
            bitIdx_reg  <= 4'h0;
            shift_reg   <= 9'h000;
            rx.wordDone <= 1'b0;
            rx.wordData <= 9'h000;
            rx.stopBit  <= 1'b1;
        end else begin
            rx.wordDone <= 1'b0;
            if (rx.sampleTick) begin
                tickCnt_reg <= tickCnt_reg + 4'h1;
            end
            if (!rx.rxRun) begin
                state_reg <= RX_IDLE;
            end else begin
                case (state_reg)
                    RX_IDLE: begin
                        if (rx.sampleTick && !rx.rxLevel) begin
                            state_reg   <= RX_START;
                            tickCnt_reg <= 4'h1;
                        end
                    end
                    RX_START: begin
                        // a start edge that is gone by mid bit is treated as a glitch
                        if (midBit) begin
                            state_reg   <= rx.rxLevel ? RX_IDLE : RX_DATA;
                            tickCnt_reg <= 4'h0;
                            bitIdx_reg  <= 4'h0;
                        end
                    end
                    RX_DATA: begin
                        // lsb first, 8 or 9 bits
                        if (bitEnd) begin
                            shift_reg  <= rx.nineBit ? {rx.rxLevel, shift_reg[8:1]}
                                                     : {1'b0, rx.rxLevel, shift_reg[7:1]};
                            bitIdx_reg <= bitIdx_reg + 4'h1;
                            if (bitIdx_reg == lastIdx) begin
                                state_reg <= RX_STOP;
                            end
                        end
                    end
                    RX_STOP: begin
                        if (bitEnd) begin
                            state_reg   <= RX_IDLE;
                            rx.wordDone <= 1'b1;
                            rx.wordData <= shift_reg;
                            rx.stopBit  <= rx.rxLevel;
                        end
                    end
                    default: state_reg <= RX_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ast_uart.sv ----
// asynchronous serial transceiver: registers, baud generator, transmitter, receive fifo
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"

// Summary of operation
// - setting transmit enable also sets the transmit buffer empty flag
// - writing transmit data while enabled starts a frame
// - receiver samples line at sixteen times the bit rate
// - reception runs only while continuous receive enable, bit 4, is set
// - after stop bit, received word moves to fifo if room
// - word in fifo sets receive-data-available flag, bit 5
// - receive-data-available is read-only, cleared only when fifo emptied
// - receive data is a two-entry fifo read in order
// - fifo full at third stop bit sets overrun, bit 1, word dropped
// - overrun blocks all further moves into the fifo
// - overrun cleared by clearing continuous receive or port enable
// - low stop bit sets framing error, bit 2
// - framing error and ninth bit travel with each fifo entry
// - frame is start, 8 or 9 data bits lsb first, stop
// - baud generator runs at 64x bit rate, or 16x when high-speed
// - shifter loads after previous stop bit; load sets buffer-empty flag
// - clearing transmit enable aborts frame and releases transmit pin
module ast_uart
    import ast_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    input  wire logic       rxPin,
    output logic            txPinOut,
    output logic            txPinOe
);
    ast_rx_if rxIf ();

    // ****************************************
    // software registers
    // ****************************************
    logic [7:0]    divisor_reg;
    logic [1:0]    intCtl_reg;
    logic          rxIrqEn_reg;
    logic          txIrqEn_reg;
    logic          portEn_reg;
    logic          nineRx_reg;
    logic          contRx_reg;
    logic          clkSrc_reg;
    logic          nineTx_reg;
    logic          tx_enable_reg;
    logic          sync_reg;
    logic          hiSpeed_reg;
    logic          bit9Tx_reg;
    logic [7:0]    txBuf_reg;
    logic          txBufFull_reg;
    logic          txFlag_reg;
    logic          overrun_reg;

    logic          wrTxStat;
    logic          wrTxData;
    logic          txEnRise;

    assign wrTxStat = regWr && regAddr == `AST_OFS_TXSTAT;
    assign wrTxData = regWr && regAddr == `AST_OFS_TXDATA;
    assign txEnRise = wrTxStat && regWrData[`AST_TX_ENABLE] && !tx_enable_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divisor_reg <= `AST_RST_BYTE;
            intCtl_reg  <= 2'b00;
            rxIrqEn_reg <= 1'b0;
            txIrqEn_reg <= 1'b0;
            portEn_reg  <= 1'b0;
            nineRx_reg  <= 1'b0;
            contRx_reg  <= 1'b0;
            clkSrc_reg  <= 1'b0;
            nineTx_reg  <= 1'b0;
            tx_enable_reg    <= 1'b0;
            sync_reg    <= 1'b0;
            hiSpeed_reg <= 1'b0;
            bit9Tx_reg  <= 1'b0;
            txBuf_reg   <= `AST_RST_BYTE;
        end else if (regWr) begin
            case (regAddr)
                `AST_OFS_DIVISOR: divisor_reg <= regWrData;
                `AST_OFS_INTCTL: begin
                    intCtl_reg <= {regWrData[`AST_INT_GLOBAL], regWrData[`AST_INT_PERIPH]};
                end
                `AST_OFS_ENABLES: begin
                    rxIrqEn_reg <= regWrData[`AST_FLG_RXAVAIL];
                    txIrqEn_reg <= regWrData[`AST_FLG_TXEMPTY];
                end
                `AST_OFS_RXSTAT: begin
                    portEn_reg <= regWrData[`AST_RX_PORTEN];
                    nineRx_reg <= regWrData[`AST_RX_NINE];
                    contRx_reg <= regWrData[`AST_RX_CONT];
                end
                `AST_OFS_TXSTAT: begin
                    clkSrc_reg  <= regWrData[`AST_TX_CLKSRC];
                    nineTx_reg  <= regWrData[`AST_TX_NINE];
                    tx_enable_reg    <= regWrData[`AST_TX_ENABLE];
                    sync_reg    <= regWrData[`AST_TX_SYNC];
                    hiSpeed_reg <= regWrData[`AST_TX_HISPEED];
                    bit9Tx_reg  <= regWrData[`AST_TX_BIT9];
                end
                `AST_OFS_TXDATA: txBuf_reg <= regWrData;
                default: ;
            endcase
        end
    end

    // ****************************************
    // receive pin synchroniser
    // ****************************************
    logic [2:0] rxSync_reg;
    logic       rxLevel_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxSync_reg  <= 3'b111;
            rxLevel_reg <= 1'b1;
        end else begin
            rxSync_reg <= {rxSync_reg[1:0], rxPin};
            // only a level that two stages agree on is taken
            if (rxSync_reg[1] == rxSync_reg[2]) begin
                rxLevel_reg <= rxSync_reg[2];
            end
        end
    end

    // ****************************************
    // baud rate generator
    // ****************************************
    logic [7:0] brgCnt_reg;
    logic [1:0] preCnt_reg;
    logic       brgTick;
    logic       sampleTick;

    assign brgTick = portEn_reg && brgCnt_reg == 8'h00;
    // x16 of bit rate: every fourth baud tick, or every baud tick when high-speed
    assign sampleTick = brgTick && (hiSpeed_reg || preCnt_reg == `AST_PRE_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brgCnt_reg <= `AST_RST_BYTE;
            preCnt_reg <= 2'h0;
        end else if (!portEn_reg || brgCnt_reg == 8'h00) begin
            // reload while the port is off keeps a divisor change from waiting out a stale count
            brgCnt_reg <= divisor_reg;
            if (brgTick) begin
                preCnt_reg <= preCnt_reg + 2'h1;
            end
        end else begin
            brgCnt_reg <= brgCnt_reg - 8'h01;
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    ast_tx_state_t txState_reg;
    logic [3:0]    txTick_reg;
    logic [3:0]    txIdx_reg;
    logic [8:0]    txShift_reg;
    logic          txNine_reg;
    logic          txRun;
    logic          txLoad;
    logic          txBitEnd;

    assign txRun    = portEn_reg && tx_enable_reg && !sync_reg;
    assign txLoad   = txRun && txState_reg == TX_IDLE && txBufFull_reg;
    assign txBitEnd = sampleTick && txTick_reg == `AST_BIT_LAST;
    assign txPinOe  = txRun;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txBufFull_reg <= 1'b0;
            txFlag_reg    <= 1'b0;
        end else begin
            // a new word occupies the buffer even if the old one leaves this cycle
            txBufFull_reg <= wrTxData || (txBufFull_reg && !txLoad);
            if (wrTxData) begin
                txFlag_reg <= 1'b0;
            end else if (txEnRise || txLoad) begin
                txFlag_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txState_reg <= TX_IDLE;
            txTick_reg  <= 4'h0;
            txIdx_reg   <= 4'h0;
            txShift_reg <= 9'h000;
            txNine_reg  <= 1'b0;
            txPinOut    <= 1'b1;
        end else if (!txRun) begin
            txState_reg <= TX_IDLE;
            txPinOut    <= 1'b1;
        end else begin
            if (sampleTick) begin
                txTick_reg <= txTick_reg + 4'h1;
            end
            case (txState_reg)
                TX_IDLE: begin
                    if (txLoad) begin
                        txShift_reg <= {bit9Tx_reg, txBuf_reg};
                        txNine_reg  <= nineTx_reg;
                        txTick_reg  <= 4'h0;
                        txPinOut    <= 1'b0;
                        txState_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (txBitEnd) begin
                        txPinOut    <= txShift_reg[0];
                        txIdx_reg   <= 4'h0;
                        txState_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (txBitEnd) begin
                        txShift_reg <= {1'b0, txShift_reg[8:1]};
                        txIdx_reg   <= txIdx_reg + 4'h1;
                        if (txIdx_reg == (txNine_reg ? `AST_LAST9 : `AST_LAST8)) begin
                            txPinOut    <= 1'b1;
                            txState_reg <= TX_STOP;
                        end else begin
                            txPinOut <= txShift_reg[1];
                        end
                    end
                end
                TX_STOP: begin
                    if (txBitEnd) begin
                        txState_reg <= TX_IDLE;
                    end
                end
                default: txState_reg <= TX_IDLE;
            endcase
        end
    end

    // ****************************************
    // receive path and fifo
    // ****************************************
    ast_rx_entry_t fifo_reg [2];
    logic [1:0]    rxCount_reg;
    logic          rxWrPtr_reg;
    logic          rxRdPtr_reg;
    logic          rxPush;
    logic          rxPop;
    logic          rxOverrun;
    ast_rx_entry_t rxHead;

    assign rxIf.sampleTick = sampleTick;
    assign rxIf.rxLevel    = rxLevel_reg;
    assign rxIf.rxRun      = portEn_reg && contRx_reg && !sync_reg;
    assign rxIf.nineBit    = nineRx_reg;

    ast_rx_shifter u_rx (
        .clk   (clk),
        .rst_n (rst_n),
        .rx    (rxIf.rcv)
    );

    assign rxPush    = rxIf.wordDone && !overrun_reg && rxCount_reg != 2'h2;
    assign rxOverrun = rxIf.wordDone && !overrun_reg && rxCount_reg == 2'h2;
    assign rxPop     = regRd && regAddr == `AST_OFS_RXDATA && rxCount_reg != 2'h0;
    assign rxHead    = fifo_reg[rxRdPtr_reg];

    for (genvar e = 0; e < 2; e++) begin : g_fifo
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                fifo_reg[e] <= '0;
            end else if (rxPush && rxWrPtr_reg == 1'(e)) begin
                fifo_reg[e].data    <= rxIf.wordData[7:0];
                fifo_reg[e].bit9    <= rxIf.wordData[8];
                fifo_reg[e].framing <= !rxIf.stopBit;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCount_reg <= 2'h0;
            rxWrPtr_reg <= 1'b0;
            rxRdPtr_reg <= 1'b0;
        end else begin
            rxCount_reg <= rxCount_reg + {1'b0, rxPush} - {1'b0, rxPop};
            if (rxPush) begin
                rxWrPtr_reg <= !rxWrPtr_reg;
            end
            if (rxPop) begin
                rxRdPtr_reg <= !rxRdPtr_reg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_reg <= 1'b0;
        end else if (!contRx_reg || !portEn_reg) begin
            overrun_reg <= 1'b0;
        end else if (rxOverrun) begin
            overrun_reg <= 1'b1;
        end
    end

    // ****************************************
    // read data, one cycle after the strobe
    // ****************************************
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        case (regAddr)
            `AST_OFS_INTCTL: begin
                rdMux[`AST_INT_GLOBAL] = intCtl_reg[1];
                rdMux[`AST_INT_PERIPH] = intCtl_reg[0];
            end
            `AST_OFS_FLAGS: begin
                rdMux[`AST_FLG_RXAVAIL] = rxCount_reg != 2'h0;
                rdMux[`AST_FLG_TXEMPTY] = txFlag_reg;
            end
            `AST_OFS_ENABLES: begin
                rdMux[`AST_FLG_RXAVAIL] = rxIrqEn_reg;
                rdMux[`AST_FLG_TXEMPTY] = txIrqEn_reg;
            end
            `AST_OFS_RXSTAT: begin
                rdMux[`AST_RX_PORTEN]  = portEn_reg;
                rdMux[`AST_RX_NINE]    = nineRx_reg;
                rdMux[`AST_RX_CONT]    = contRx_reg;
                rdMux[`AST_RX_FRAMING] = rxHead.framing;
                rdMux[`AST_RX_OVERRUN] = overrun_reg;
                rdMux[`AST_RX_BIT9]    = rxHead.bit9;
            end
            `AST_OFS_TXSTAT: begin
                rdMux[`AST_TX_CLKSRC]  = clkSrc_reg;
                rdMux[`AST_TX_NINE]    = nineTx_reg;
                rdMux[`AST_TX_ENABLE]  = tx_enable_reg;
                rdMux[`AST_TX_SYNC]    = sync_reg;
                rdMux[`AST_TX_HISPEED] = hiSpeed_reg;
                rdMux[`AST_TX_SHEMPTY] = txState_reg == TX_IDLE;
                rdMux[`AST_TX_BIT9]    = bit9Tx_reg;
            end
            `AST_OFS_TXDATA:  rdMux = txBuf_reg;
            `AST_OFS_RXDATA:  rdMux = rxHead.data;
            `AST_OFS_DIVISOR: rdMux = divisor_reg;
            default:          rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- dv/ast_uart_checker.sv ----
// port-level assertions for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"
module ast_uart_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       rxPin,
    input wire logic       txPinOut,
    input wire logic       txPinOe
);
    logic [4:0] offCnt_reg;
    logic       freshEn_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ******
    // helper and checks
    // ******
    // cycles the transmitter has been released; a long release means the shifter is idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offCnt_reg <= 5'h00;
        end else if (txPinOe) begin
            offCnt_reg <= 5'h00;
        end else if (offCnt_reg != 5'h1f) begin
            offCnt_reg <= offCnt_reg + 5'h01;
        end
    end
    // no frame begun since the last release; a high run alone cannot tell idle from data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freshEn_reg <= 1'b1;
        end else begin
            freshEn_reg <= !txPinOe || (freshEn_reg && txPinOut);
        end
    end
    read_quiet_a: assert property (
        regRdData != 8'h00 |-> $past(regRd))
        else $error("read data without read");
    unmapped_read_a: assert property (
        regRd && regAddr == 8'h1b |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    flag_pad_a: assert property (
        regRd && regAddr == `AST_OFS_FLAGS |=> (regRdData & 8'hcf) == 8'h00)
        else $error("flag spare bits set");
    shift_empty_a: assert property (
        regRd && regAddr == `AST_OFS_TXSTAT && offCnt_reg == 5'h1f |=> regRdData[1])
        else $error("shift empty clear while idle");
    tx_flag_set_a: assert property (
        regWr && regAddr == `AST_OFS_TXSTAT && regWrData[5]
        ##1 regRd && regAddr == `AST_OFS_FLAGS |=> regRdData[4])
        else $error("enable did not set tx flag");
    tx_start_a: assert property (
        regWr && regAddr == `AST_OFS_TXDATA && txPinOe && freshEn_reg |-> ##[1:2] !txPinOut)
        else $error("write did not start frame");
    start_width_a: assert property (
        $fell(txPinOut) |-> (!txPinOut || !txPinOe) [*8])
        else $error("low bit too short");
    tx_abort_a: assert property (
        regWr && regAddr == `AST_OFS_TXSTAT && !regWrData[5] |=> !txPinOe)
        else $error("pin still driven after disable");
    idle_high_a: assert property (
        !txPinOe |=> txPinOut)
        else $error("released pin not high");
    cover property (regWr && regAddr == `AST_OFS_TXDATA);
    cover property (regRd && regAddr == `AST_OFS_RXDATA);
    cover property ($fell(txPinOe));
endmodule
`default_nettype wire

// ---- dv/ast_serial_node.sv ----
// remote serial node: sends frames on the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_serial_node #(
    parameter int BIT_CLKS = 16
) (
    input  wire logic clk,
    input  wire logic txLine,
    input  wire logic nine,
    output var logic  rxLine
);
    logic [8:0] gotWord;
    logic       gotStop;
    int         gotCount = 0;
    // ******
    // sender and monitor
    // ******
    initial rxLine = 1'b1;
    task automatic send(input logic [8:0] w, input int nBits, input logic stopLvl);
        rxLine <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < nBits; i++) begin
            rxLine <= w[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        rxLine <= stopLvl;
        repeat (BIT_CLKS) @(posedge clk);
        rxLine <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge clk);
    endtask
    initial forever begin
        @(negedge txLine);
        gotWord = 9'h000;
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8 + int'(nine); i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            gotWord[i] = txLine;
        end
        repeat (BIT_CLKS) @(posedge clk);
        gotStop = txLine;
        gotCount++;
    end
endmodule
`default_nettype wire

// ---- dv/tb_async_serial_transceiver.sv ----
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`default_nettype none
`include "ast_consts.svh"
module tb_async_serial_transceiver;
    logic       clk, rst_n, regWr, regRd, rxPin, txPinOut, txPinOe, txWire, nine;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [8:0] rdv;
    int         miscompares = 0;
    int         nChecks = 0;
    // released pin is pulled high
    assign txWire = txPinOe ? txPinOut : 1'b1;
    ast_uart i_ast_uart (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxPin(rxPin),
        .txPinOut(txPinOut), .txPinOe(txPinOe));
    ast_serial_node i_ast_serial_node (.clk(clk), .txLine(txWire), .nine(nine), .rxLine(rxPin));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ******
    // bus and compare
    // ******
    task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
        nChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        @(negedge clk);
        rdv = {1'b0, regRdData};
    endtask
    task automatic wait_frames(input int n);
        for (int i = 0; i < 2000 && i_ast_serial_node.gotCount < n; i++) @(posedge clk);
        chk("frames", 9'(i_ast_serial_node.gotCount), 9'(n));
        chk("stop", {8'h00, i_ast_serial_node.gotStop}, 9'h001);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ******
    // scenarios
    // ******
    task automatic tx_frames();
        wr(`AST_OFS_DIVISOR, 8'h00);
        wr(`AST_OFS_INTCTL, 8'hc0);
        rd(`AST_OFS_INTCTL);
        chk("intctl", rdv, 9'h0c0);
        wr(`AST_OFS_RXSTAT, 8'h90);
        op(1'b1, 1'b0, `AST_OFS_TXSTAT, 8'h65);
        rd(`AST_OFS_FLAGS);
        chk("txflag", rdv, 9'h010);
        nine = 1'b1;
        wr(`AST_OFS_TXDATA, 8'ha5);
        rd(`AST_OFS_TXSTAT);
        chk("busy", rdv, 9'h065);
        wait_frames(1);
        chk("word", i_ast_serial_node.gotWord, 9'h1a5);
        wr(`AST_OFS_TXDATA, 8'h3c);
        rd(`AST_OFS_FLAGS);
        chk("held", rdv, 9'h000);
        for (int i = 0; i < 16 && rdv[4] !== 1'b1; i++) rd(`AST_OFS_FLAGS);
        chk("loaded", {8'h00, rdv[4]}, 9'h001);
        wr(`AST_OFS_TXDATA, 8'hc3);
        rd(`AST_OFS_FLAGS);
        chk("full", rdv, 9'h000);
        wait_frames(3);
        chk("second", i_ast_serial_node.gotWord, 9'h1c3);
    endtask
    task automatic rx_frames();
        i_ast_serial_node.send(9'h03c, 8, 1'b1);
        i_ast_serial_node.send(9'h0c3, 8, 1'b0);
        i_ast_serial_node.send(9'h05a, 8, 1'b1);
        rd(`AST_OFS_FLAGS);
        chk("avail", rdv, 9'h030);
        rd(`AST_OFS_RXSTAT);
        chk("overrun", rdv, 9'h092);
        rd(`AST_OFS_RXDATA);
        chk("data1", rdv, 9'h03c);
        rd(`AST_OFS_RXSTAT);
        chk("framing", rdv, 9'h096);
        rd(`AST_OFS_RXDATA);
        chk("data2", rdv, 9'h0c3);
        rd(`AST_OFS_FLAGS);
        chk("drained", rdv, 9'h010);
        wr(`AST_OFS_RXSTAT, 8'h80);
        i_ast_serial_node.send(9'h0ff, 8, 1'b1);
        rd(`AST_OFS_FLAGS);
        chk("rxoff", rdv, 9'h010);
        wr(`AST_OFS_RXSTAT, 8'hd0);
        rd(`AST_OFS_RXSTAT);
        chk("ovclear", {8'h00, rdv[1]}, 9'h000);
        i_ast_serial_node.send(9'h155, 9, 1'b1);
        rd(`AST_OFS_RXSTAT);
        chk("bit9", rdv, 9'h0d1);
        rd(`AST_OFS_RXDATA);
        chk("data9", rdv, 9'h055);
    endtask
    task automatic tx_abort();
        wr(`AST_OFS_TXDATA, 8'h00);
        repeat (20) @(posedge clk);
        wr(`AST_OFS_TXSTAT, 8'h04);
        @(negedge clk);
        chk("oe", {8'h00, txPinOe}, 9'h000);
        rd(`AST_OFS_TXSTAT);
        chk("txreset", rdv, 9'h006);
    endtask
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        nine = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge clk);
        rd(`AST_OFS_TXSTAT);
        chk("txstat", rdv, 9'h002);
        rd(8'h1b);
        chk("unmapped", rdv, 9'h000);
        tx_frames();
        rx_frames();
        tx_abort();
        end_of_test();
    end
endmodule
bind ast_uart ast_uart_checker i_ast_uart_checker (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rxPin(rxPin), .txPinOut(txPinOut), .txPinOe(txPinOe));
`default_nettype wire
